//--- rtl/isfcr_consts.svh
// Operation
// - month BCD in factory date upper byte
// - day BCD in factory date lower byte
// - year four BCD digits, whole word
// - fixed product code word, read only
// - lot specific serial number, read only
// - three scratch words read back as written
// - 32-bit counter counts flash write cycles
// - counter low word at lower pair
// - counter high word at next pair
// - busy command stops data and serial
`ifndef ISFCR_CONSTS_SVH
`define ISFCR_CONSTS_SVH

// =====================================================
// register byte addresses (even byte of each pair, except the odd command high byte)
`define ISFCR_OFS_MONTH_DAY  7'h6E
`define ISFCR_OFS_YEAR       7'h70
`define ISFCR_OFS_PRODUCT    7'h72
`define ISFCR_OFS_SERIAL     7'h74
`define ISFCR_OFS_SCR_ONE    7'h76
`define ISFCR_OFS_SCR_TWO    7'h78
`define ISFCR_OFS_SCR_THREE  7'h7A
`define ISFCR_OFS_CNT_LOW    7'h7C
`define ISFCR_OFS_CNT_HIGH   7'h7E
`define ISFCR_OFS_CMD_LOW    7'h68
`define ISFCR_OFS_CMD_HIGH   7'h69

// =====================================================
// field positions and frame layout
`define ISFCR_CMD_FLASH_BIT  3
`define ISFCR_WR_BIT         15
`define ISFCR_FRAME_LAST     5'h0F
`define ISFCR_SLOT_SCR_BASE  4
`define ISFCR_SLOT_NONE      4'hF

// =====================================================
// reset values and identity
`define ISFCR_WORD_RST       16'h0000
`define ISFCR_BYTE_RST       8'h00
`define ISFCR_CNT_RST        32'h0000_0000
`define ISFCR_CNT_STEP       32'h0000_0001
`define ISFCR_PRODUCT_CODE   16'h5A5A

// =====================================================
// timing
`define ISFCR_CLK_MHZ        40
`define ISFCR_UPDATE_TIME_US 1000

`endif

//--- rtl/isfcr_pkg.sv
// =====================================================
// shared types
package isfcr_pkg;
    typedef logic [15:0] isfcr_word_t;   // one register word
    typedef logic [6:0]  isfcr_addr_t;   // byte address
    typedef enum logic [1:0] {
        ISFCR_ST_IDLE = 2'b01,           // serial port live
        ISFCR_ST_BUSY = 2'b10            // global command running
    } isfcr_cmd_state_e;
endpackage

//--- rtl/isfcr_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// frame engine to register bank link
interface isfcr_reg_if;
    logic                 wrEn;     // byte write strobe
    isfcr_pkg::isfcr_addr_t wrAddr; // byte address written
    logic [7:0]           wrData;   // byte written
    isfcr_pkg::isfcr_addr_t rdAddr; // byte address read
    isfcr_pkg::isfcr_word_t rdData; // word at rdAddr pair
    logic                 flashInc; // one flash write cycle
    modport master (output wrEn, wrAddr, wrData, rdAddr, flashInc,
                    input rdData);
    modport slave  (input wrEn, wrAddr, wrData, rdAddr, flashInc,
                    output rdData);
endinterface
`default_nettype wire

//--- rtl/isfcr_reg_bank.sv
`include "isfcr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// identity, scratch and flash counter words
module isfcr_reg_bank #(
    parameter logic [15:0] PRODUCT_CODE = `ISFCR_PRODUCT_CODE // arbitrary
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    isfcr_reg_if.slave      bus,
    input  wire logic [7:0] factoryMonth,
    input  wire logic [7:0] factoryDay,
    input  wire logic [15:0] factoryYear,
    input  wire logic [15:0] unitSerial
);
    // =================================================
    // address pair to slot decode, used for write and read
    function automatic logic [3:0] regSlot(input logic [6:0] a);
        logic [6:0] even;
        even = {a[6:1], 1'b0};
        case (even)
            `ISFCR_OFS_MONTH_DAY: regSlot = 4'h0;
            `ISFCR_OFS_YEAR:      regSlot = 4'h1;
            `ISFCR_OFS_PRODUCT:   regSlot = 4'h2;
            `ISFCR_OFS_SERIAL:    regSlot = 4'h3;
            `ISFCR_OFS_SCR_ONE:   regSlot = 4'h4;
            `ISFCR_OFS_SCR_TWO:   regSlot = 4'h5;
            `ISFCR_OFS_SCR_THREE: regSlot = 4'h6;
            `ISFCR_OFS_CNT_LOW:   regSlot = 4'h7;
            `ISFCR_OFS_CNT_HIGH:  regSlot = 4'h8;
            default:              regSlot = `ISFCR_SLOT_NONE;
        endcase
    endfunction

    wire logic [3:0]  wrSlot = regSlot(bus.wrAddr); // slot being written
    wire logic [3:0]  rdSlot = regSlot(bus.rdAddr); // slot being read
    logic      [15:0] scratch_ff [3];               // user words
    logic      [31:0] flashCnt_ff;                  // write cycles

    // =================================================
    // scratch words, byte writable; even byte is low
    // read-only slots have no write path at all
    for (genvar g = 0; g < 3; g++) begin : gScratch
        localparam logic [3:0] SLOT = 4'(g + `ISFCR_SLOT_SCR_BASE);
        wire logic hit = bus.wrEn && (wrSlot == SLOT);
        // volatile until a flash update is issued by host
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                scratch_ff[g] <= `ISFCR_WORD_RST;
            end else if (hit && bus.wrAddr[0]) begin
                scratch_ff[g][15:8] <= bus.wrData;
            end else if (hit) begin
                scratch_ff[g][7:0] <= bus.wrData;
            end
        end
    end

    // =================================================
    // flash write counter, wraps silently at 2^32
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flashCnt_ff <= `ISFCR_CNT_RST;
        end else if (bus.flashInc) begin
            flashCnt_ff <= flashCnt_ff + `ISFCR_CNT_STEP;
        end
    end

    // =================================================
    // read selection; unmapped pairs read as zero
    assign bus.rdData =
        (rdSlot == 4'h0) ? {factoryMonth, factoryDay} :
        (rdSlot == 4'h1) ? factoryYear :
        (rdSlot == 4'h2) ? PRODUCT_CODE :
        (rdSlot == 4'h3) ? unitSerial :
        (rdSlot == 4'h4) ? scratch_ff[0] :
        (rdSlot == 4'h5) ? scratch_ff[1] :
        (rdSlot == 4'h6) ? scratch_ff[2] :
        (rdSlot == 4'h7) ? flashCnt_ff[15:0] :
        (rdSlot == 4'h8) ? flashCnt_ff[31:16] :
        `ISFCR_WORD_RST;
endmodule
`default_nettype wire

//--- rtl/isfcr_top.sv
`include "isfcr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// serial frame engine, global command and bank wrapper
module isfcr_top #(
    parameter int unsigned UPDATE_TIME_US = `ISFCR_UPDATE_TIME_US,
    parameter logic [31:0] UPDATE_CYCLES  =
        32'(UPDATE_TIME_US * `ISFCR_CLK_MHZ)
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic        din,
    output var  logic        dout,
    input  wire logic        sampleReadyIn,
    output var  logic        sample_ready_out,
    output var  logic        cmdBusy,
    input  wire logic [7:0]  factoryMonth,
    input  wire logic [7:0]  factoryDay,
    input  wire logic [15:0] factoryYear,
    input  wire logic [15:0] unitSerial
);
    // =================================================
    // state
    isfcr_reg_if bus ();

    logic                      sclkPrev_ff;   // last sclk level
    logic                      csPrev_ff;     // last chip select level
    logic [4:0]                bitCnt_ff;     // bits taken this frame
    logic [15:0]               rxShift_ff;    // incoming frame
    logic [15:0]               txShift_ff;    // outgoing frame
    logic [15:0]               rdHold_ff;     // word for next frame
    logic [7:0]                cmdLow_ff;     // low command byte
    logic [31:0]               busyCnt_ff;    // cycles left in command
    logic                      dout_ff;       // serial output bit
    logic                      readyOut_ff;   // gated data ready
    logic                      cmdBusy_ff;    // command running flag
    isfcr_pkg::isfcr_cmd_state_e state_ff;    // command machine
    isfcr_pkg::isfcr_cmd_state_e nxt_state;   // next machine state

    // =================================================
    // frame decode; pins are synchronous so no synchroniser
    wire logic idle       = (state_ff == isfcr_pkg::ISFCR_ST_IDLE);
    wire logic sclkRise   = sclk && !sclkPrev_ff && !csN;
    wire logic sclkFall   = !sclk && sclkPrev_ff && !csN;
    wire logic frameStart = !csN && csPrev_ff;
    // serial port dead while a command runs
    wire logic takeBit    = sclkRise && idle;
    wire logic frameDone  = takeBit && (bitCnt_ff == `ISFCR_FRAME_LAST);
    wire logic [15:0] rxWord    = {rxShift_ff[14:0], din};
    wire logic        isWrite   = rxWord[`ISFCR_WR_BIT];
    wire logic [6:0]  frameAddr = rxWord[14:8];
    wire logic [7:0]  frameData = rxWord[7:0];
    wire logic wrFrame  = frameDone && isWrite;
    wire logic rdFrame  = frameDone && !isWrite;
    wire logic cmdLoHit = wrFrame && (frameAddr == `ISFCR_OFS_CMD_LOW);
    wire logic cmdHiHit = wrFrame && (frameAddr == `ISFCR_OFS_CMD_HIGH);
    // command fires on the high byte, using the stored low byte
    wire logic startUpdate =
        cmdHiHit && cmdLow_ff[`ISFCR_CMD_FLASH_BIT];
    wire logic busyDone = (busyCnt_ff == `ISFCR_CNT_RST);

    // =================================================
    // bank link
    assign bus.wrEn     = wrFrame;
    assign bus.wrAddr   = frameAddr;
    assign bus.wrData   = frameData;
    assign bus.rdAddr   = frameAddr;
    assign bus.flashInc = startUpdate; // one count per backup

    // =================================================
    // edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrev_ff <= 1'b1;
            csPrev_ff   <= 1'b1;
        end else begin
            sclkPrev_ff <= sclk;
            csPrev_ff   <= csN;
        end
    end

    // =================================================
    // bit counter, cleared between frames
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_ff <= 5'h00;
        end else if (csN || frameDone) begin
            bitCnt_ff <= 5'h00;
        end else if (takeBit) begin
            bitCnt_ff <= bitCnt_ff + 5'h01;
        end
    end

    // =================================================
    // receive shifter, msb first on rising sclk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxShift_ff <= `ISFCR_WORD_RST;
        end else if (takeBit) begin
            rxShift_ff <= rxWord;
        end
    end

    // =================================================
    // read answer held for the following frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdHold_ff <= `ISFCR_WORD_RST;
        end else if (rdFrame) begin
            rdHold_ff <= bus.rdData;
        end
    end

    // =================================================
    // transmit shifter; bit launched on falling sclk
    // a frame opened during a command shifts out nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txShift_ff <= `ISFCR_WORD_RST;
            dout_ff    <= 1'b0;
        end else if (csN) begin
            dout_ff    <= 1'b0;
        end else if (frameStart) begin
            txShift_ff <= idle ? rdHold_ff : `ISFCR_WORD_RST;
        end else if (sclkFall && idle) begin
            dout_ff    <= txShift_ff[15];
            txShift_ff <= {txShift_ff[14:0], 1'b0};
        end
    end

    // =================================================
    // low command byte waits for its high companion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdLow_ff <= `ISFCR_BYTE_RST;
        end else if (cmdHiHit) begin
            cmdLow_ff <= `ISFCR_BYTE_RST;
        end else if (cmdLoHit) begin
            cmdLow_ff <= frameData;
        end
    end

    // =================================================
    // command machine next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            isfcr_pkg::ISFCR_ST_IDLE: begin
                if (startUpdate) begin
                    nxt_state = isfcr_pkg::ISFCR_ST_BUSY;
                end
            end
            isfcr_pkg::ISFCR_ST_BUSY: begin
                if (busyDone) begin
                    nxt_state = isfcr_pkg::ISFCR_ST_IDLE;
                end
            end
            default: begin
                nxt_state = isfcr_pkg::ISFCR_ST_IDLE;
            end
        endcase
    end

    // =================================================
    // command machine and busy timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= isfcr_pkg::ISFCR_ST_IDLE;
            busyCnt_ff <= `ISFCR_CNT_RST;
            cmdBusy_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cmdBusy_ff <= (nxt_state == isfcr_pkg::ISFCR_ST_BUSY);
            if (startUpdate) begin
                busyCnt_ff <= UPDATE_CYCLES - `ISFCR_CNT_STEP;
            end else if (!busyDone) begin
                busyCnt_ff <= busyCnt_ff - `ISFCR_CNT_STEP;
            end
        end
    end

    // =================================================
    // data ready passes only while no command runs
    // costs one cycle of latency but keeps the pin glitch free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readyOut_ff <= 1'b0;
        end else begin
            readyOut_ff <= sampleReadyIn && idle && !startUpdate;
        end
    end

    assign dout             = dout_ff;
    assign sample_ready_out = readyOut_ff;
    assign cmdBusy          = cmdBusy_ff;

    // =================================================
    // register bank
    isfcr_reg_bank u_bank (
        .clk          (clk),
        .rst_n        (rst_n),
        .bus          (bus.slave),
        .factoryMonth (factoryMonth),
        .factoryDay   (factoryDay),
        .factoryYear  (factoryYear),
        .unitSerial   (unitSerial)
    );
endmodule
`default_nettype wire

//--- tb/isfcr_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checks: data ready, busy span, dout
module isfcr_top_assertions #(
    parameter logic [31:0] UPDATE_CYCLES = 32'h0000_9C40
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic dout,
    input wire logic sampleReadyIn,
    input wire logic sample_ready_out,
    input wire logic cmdBusy
);
    logic [31:0] busyCnt_ff;  // cycles spent busy so far
    logic [31:0] nxt_busyCnt; // clears on any idle cycle
    assign nxt_busyCnt = cmdBusy ? busyCnt_ff + 32'h1 : 32'h0;
    // counter instead of a long repetition, which tools unroll
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt_ff <= 32'h0;
        end else begin
            busyCnt_ff <= nxt_busyCnt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // assertions
    // gate is registered, so ready resumes one cycle after busy drops
    a_ready_delay: assert property ($past(sampleReadyIn)
        && $past(rst_n) && !$past(cmdBusy) && !cmdBusy
        |-> sample_ready_out)
        else $error("data ready not passed on after one cycle");
    a_ready_drop: assert property (!$past(sampleReadyIn)
        |-> !sample_ready_out)
        else $error("data ready pulse without a cause");
    a_ready_mute: assert property (cmdBusy |-> !sample_ready_out)
        else $error("data ready pulsed during a command");
    a_busy_len: assert property ($fell(cmdBusy)
        |-> busyCnt_ff == UPDATE_CYCLES)
        else $error("busy period has the wrong length");
    a_busy_cap: assert property (busyCnt_ff <= UPDATE_CYCLES)
        else $error("busy period runs too long");
    a_busy_start: assert property ($rose(cmdBusy) |-> !csN && sclk)
        else $error("command started outside a frame end");
    a_dout_idle: assert property (csN && $past(csN) |-> !dout)
        else $error("dout driven while deselected");
    a_dout_hold: assert property (!csN && !$past(csN) && !$past(csN, 2)
        && sclk && $past(sclk) |-> $stable(dout))
        else $error("dout moved while serial clock high");
    // main scenarios reached
    c_busy_rise: cover property ($rose(cmdBusy));
    c_busy_fall: cover property ($fell(cmdBusy));
    c_ready_out: cover property (sample_ready_out);
endmodule
bind isfcr_top isfcr_top_assertions #(
    .UPDATE_CYCLES(UPDATE_CYCLES)
) u_chk (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .dout(dout),
    .sampleReadyIn(sampleReadyIn), .sample_ready_out(sample_ready_out),
    .cmdBusy(cmdBusy)
);
`default_nettype wire

//--- tb/isfcr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// serial host: mode 3, msb first, 4 clk halves
module isfcr_host_model (
    input  wire logic clk,
    output var  logic sclk,
    output var  logic csN,
    output var  logic din,
    input  wire logic dout
);
    // idle: deselected, clock parked high
    initial begin
        sclk = 1'b1;
        csN = 1'b1;
        din = 1'b0;
    end
    // one frame; rx takes dout at each rising sclk edge
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge clk);
        csN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b0;
            din <= tx[i];
            repeat (4) @(posedge clk);
            rx[i] = dout;
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        csN <= 1'b1;
        // released line shows a changed level, not the last bit
        din <= ~din;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`include "isfcr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench for the identity and scratch bank
module tb;
    localparam logic [31:0] BUSY = 32'h0000_00C8; // short update span
    logic        clk;
    logic        rst_n;
    logic        sclk;
    logic        csN;
    logic        din;
    logic        dout;
    logic        rdyIn;
    logic        rdyOut;
    logic        cmdBusy;
    logic [15:0] rdWord;   // last answer from the host
    int          fails;
    int          samples_checked;
    logic [15:0] scr [3] = '{16'h1357, 16'hFFFF, 16'h8001};
    logic [6:0]  ro [6] = '{7'h6E, 7'h71, 7'h72, 7'h75, 7'h7C, 7'h7F};
    isfcr_top #(
        .UPDATE_CYCLES(BUSY)
    ) u_dut (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .din(din),
        .dout(dout), .sampleReadyIn(rdyIn), .sample_ready_out(rdyOut),
        .cmdBusy(cmdBusy), .factoryMonth(8'h11), .factoryDay(8'h27),
        .factoryYear(16'h2017), .unitSerial(16'h5EA1)
    );
    isfcr_host_model u_host (
        .clk(clk), .sclk(sclk), .csN(csN), .din(din), .dout(dout)
    );
    // ==========================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        u_host.xfer({1'b1, addr, data}, rdWord);
    endtask
    // answer arrives in the following frame
    task automatic rd(input logic [6:0] addr, input logic [15:0] exp);
        u_host.xfer({1'b0, addr, 8'h00}, rdWord);
        u_host.xfer(16'h0000, rdWord);
        check(rdWord, exp);
    endtask
    task automatic stop_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // bounded wait for the update to finish
    task automatic wait_idle();
        for (int i = 0; i < 400 && cmdBusy !== 1'b0; i++) begin
            @(posedge clk);
        end
        if (cmdBusy !== 1'b0) begin
            fails++;
            stop_test();
        end
    endtask
    // ==========================================
    // clock and main sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        rdyIn = 1'b0;
        fails = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(7'h6E, 16'h1127);
        rd(7'h70, 16'h2017);
        rd(7'h72, `ISFCR_PRODUCT_CODE);
        rd(7'h73, `ISFCR_PRODUCT_CODE);
        rd(7'h74, 16'h5EA1);
        // byte writes build each scratch word
        for (int k = 0; k < 3; k++) begin
            wr(7'h76 + 7'(2 * k), scr[k][7:0]);
            wr(7'h77 + 7'(2 * k), scr[k][15:8]);
        end
        for (int k = 0; k < 3; k++) begin
            rd(7'h76 + 7'(2 * k), scr[k]);
        end
        // read-only places must shrug off writes
        for (int k = 0; k < 6; k++) begin
            wr(ro[k], 8'hFF);
        end
        rd(7'h6E, 16'h1127);
        rd(7'h72, `ISFCR_PRODUCT_CODE);
        rd(7'h74, 16'h5EA1);
        rd(7'h7C, 16'h0000);
        rd(7'h7E, 16'h0000);
        // flash update: low byte, then high byte
        wr(7'h68, 8'h08);
        wr(7'h69, 8'h00);
        check({15'h0000, cmdBusy}, 16'h0001);
        rdyIn <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        check({15'h0000, rdyOut}, 16'h0000);
        @(posedge clk);
        rdyIn <= 1'b0;
        // whole frame inside the busy span is dropped
        wr(7'h76, 8'h00);
        wait_idle();
        rdyIn <= 1'b1;
        @(negedge clk);
        check({15'h0000, rdyOut}, 16'h0000);
        @(negedge clk);
        check({15'h0000, rdyOut}, 16'h0001);
        // bench inputs only move on the rising edge
        @(posedge clk);
        rdyIn <= 1'b0;
        rd(7'h76, scr[0]);
        rd(7'h7C, 16'h0001);
        rd(7'h7E, 16'h0000);
        // second update counts again
        wr(7'h68, 8'h08);
        wr(7'h69, 8'h00);
        wait_idle();
        // high byte alone: stored low byte was consumed
        wr(7'h69, 8'h00);
        check({15'h0000, cmdBusy}, 16'h0000);
        // another command bit must not start a backup
        wr(7'h68, 8'h04);
        wr(7'h69, 8'h00);
        check({15'h0000, cmdBusy}, 16'h0000);
        rd(7'h7C, 16'h0002);
        stop_test();
    end
endmodule
`default_nettype wire
